//--- design/dpa_params.svh
`ifndef DPA_PARAMS_SVH
`define DPA_PARAMS_SVH

// Register indices; the byte address is four times the index
`define DPA_IDX_ANALOG_PORT_LATCH 12'h006
`define DPA_IDX_SEGMENT_PORT_LATCH 12'h007
`define DPA_IDX_ANALOG_PORT_DIRECTION 12'h014
`define DPA_IDX_ANALOG_PORT_INPUT_SELECT 12'h015
`define DPA_IDX_SEGMENT_PORT_PIN_READBACK 12'h024
`define DPA_IDX_SEGMENT_PORT_FUNCTION_SELECT 12'hfaf

// Reset values
`define DPA_RST_ANALOG_PORT_LATCH 8'h00
`define DPA_RST_SEGMENT_PORT_LATCH 8'hff
`define DPA_RST_ANALOG_PORT_DIRECTION 8'h00
`define DPA_RST_ANALOG_PORT_INPUT_SELECT 8'hff
`define DPA_RST_SEGMENT_PORT_FUNCTION_SELECT 8'h00
`define DPA_RST_SEGMENT_PORT_PIN_READBACK 8'h00

// Bus encodings
`define DPA_HTRANS_NONSEQ 2'h2
`define DPA_HRESP_OKAY 1'h0

`endif

//--- design/dpa_pkg.sv
package dpa_pkg;

  typedef logic [7:0] dpa_byte_type;

  typedef enum logic [2:0] {
    DPA_SEL_NONE = 3'b000,
    DPA_SEL_ANA_LATCH = 3'b001,
    DPA_SEL_SEG_LATCH = 3'b010,
    DPA_SEL_ANA_DIR = 3'b011,
    DPA_SEL_ANA_INSEL = 3'b100,
    DPA_SEL_SEG_READBACK = 3'b101,
    DPA_SEL_SEG_FUNC = 3'b110
  } dpa_reg_sel_type;

endpackage

//--- design/dpa_port_io.sv
// Functional notes
// - Select 1: LCD driver owns pin
// - Reset: segment latch ones, select zeros
// - Segment latch and readback separate addresses
// - Latch reads latch; readback reads pins
// - Readback of segment pins undefined
// - Direction bit: 0 input, 1 output
// - Input select: 0 analog, 1 digital input
// - Reset: latch, direction zero; select ones
// - Input-mode read returns pin level
// - Read: 0, pin, or latch per mode
`include "dpa_params.svh"

module dpa_port_io (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] analogPinIn,
  output logic [7:0] analogPinOut,
  output logic [7:0] analogPinOe,
  output logic [7:0] analogDigitalIn,
  output logic [7:0] analogChannelEnable,
  input wire logic [7:0] segmentPinIn,
  output logic [7:0] segmentPinOut,
  output logic [7:0] segmentPinOe,
  input wire logic [7:0] lcdSegmentDrive
);

  dpa_pkg::dpa_byte_type anaLatch_reg;
  dpa_pkg::dpa_byte_type anaLatch_next;
  dpa_pkg::dpa_byte_type anaDir_reg;
  dpa_pkg::dpa_byte_type anaDir_next;
  dpa_pkg::dpa_byte_type anaInSel_reg;
  dpa_pkg::dpa_byte_type anaInSel_next;
  dpa_pkg::dpa_byte_type segLatch_reg;
  dpa_pkg::dpa_byte_type segLatch_next;
  dpa_pkg::dpa_byte_type segFunc_reg;
  dpa_pkg::dpa_byte_type segFunc_next;

  // Pin synchronisers
  dpa_pkg::dpa_byte_type anaMeta_reg;
  dpa_pkg::dpa_byte_type anaSync_reg;
  dpa_pkg::dpa_byte_type segMeta_reg;
  dpa_pkg::dpa_byte_type segSync_reg;

  // Data phase bookkeeping
  logic wrPending_reg;
  dpa_pkg::dpa_reg_sel_type wrSel_reg;

  logic addrPhase;
  logic [11:0] regIndex;
  logic addrInRange;
  dpa_pkg::dpa_reg_sel_type addrSel;
  dpa_pkg::dpa_byte_type wrByte;
  logic wrAnaLatch;
  logic wrSegLatch;
  logic wrAnaDir;
  logic wrAnaInSel;
  logic wrSegFunc;
  dpa_pkg::dpa_byte_type anaReadValue;
  dpa_pkg::dpa_byte_type readByte;
  dpa_pkg::dpa_byte_type anaPinOut_next;
  dpa_pkg::dpa_byte_type anaPinOe_next;
  dpa_pkg::dpa_byte_type segPinOut_next;
  dpa_pkg::dpa_byte_type segPinOe_next;

  // Address decode
  assign addrPhase = hsel && hready && (htrans == `DPA_HTRANS_NONSEQ || htrans == 2'h3);
  assign regIndex = haddr[13:2];
  assign addrInRange = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);

  assign addrSel =
    !addrInRange ? dpa_pkg::DPA_SEL_NONE :
    (regIndex == `DPA_IDX_ANALOG_PORT_LATCH) ? dpa_pkg::DPA_SEL_ANA_LATCH :
    (regIndex == `DPA_IDX_SEGMENT_PORT_LATCH) ? dpa_pkg::DPA_SEL_SEG_LATCH :
    (regIndex == `DPA_IDX_ANALOG_PORT_DIRECTION) ? dpa_pkg::DPA_SEL_ANA_DIR :
    (regIndex == `DPA_IDX_ANALOG_PORT_INPUT_SELECT) ? dpa_pkg::DPA_SEL_ANA_INSEL :
    (regIndex == `DPA_IDX_SEGMENT_PORT_PIN_READBACK) ? dpa_pkg::DPA_SEL_SEG_READBACK :
    (regIndex == `DPA_IDX_SEGMENT_PORT_FUNCTION_SELECT) ? dpa_pkg::DPA_SEL_SEG_FUNC :
    dpa_pkg::DPA_SEL_NONE;

  // Write strobes in the data phase; the readback register ignores writes
  assign wrByte = hwdata[7:0];
  assign wrAnaLatch = wrPending_reg && (wrSel_reg == dpa_pkg::DPA_SEL_ANA_LATCH);
  assign wrSegLatch = wrPending_reg && (wrSel_reg == dpa_pkg::DPA_SEL_SEG_LATCH);
  assign wrAnaDir = wrPending_reg && (wrSel_reg == dpa_pkg::DPA_SEL_ANA_DIR);
  assign wrAnaInSel = wrPending_reg && (wrSel_reg == dpa_pkg::DPA_SEL_ANA_INSEL);
  assign wrSegFunc = wrPending_reg && (wrSel_reg == dpa_pkg::DPA_SEL_SEG_FUNC);

  assign anaLatch_next = wrAnaLatch ? wrByte : anaLatch_reg;
  assign segLatch_next = wrSegLatch ? wrByte : segLatch_reg;
  assign anaDir_next = wrAnaDir ? wrByte : anaDir_reg;
  assign anaInSel_next = wrAnaInSel ? wrByte : anaInSel_reg;
  assign segFunc_next = wrSegFunc ? wrByte : segFunc_reg;

  // Per bit: latch in output mode, pin if digital input on, else zero
  assign anaReadValue = (anaDir_next & anaLatch_next) |
    (~anaDir_next & anaInSel_next & anaSync_reg);

  // Read mux uses next values so a read right behind a write sees it
  assign readByte =
    (addrSel == dpa_pkg::DPA_SEL_ANA_LATCH) ? anaReadValue :
    (addrSel == dpa_pkg::DPA_SEL_SEG_LATCH) ? segLatch_next :
    (addrSel == dpa_pkg::DPA_SEL_ANA_DIR) ? anaDir_next :
    (addrSel == dpa_pkg::DPA_SEL_ANA_INSEL) ? anaInSel_next :
    (addrSel == dpa_pkg::DPA_SEL_SEG_READBACK) ? segSync_reg :
    (addrSel == dpa_pkg::DPA_SEL_SEG_FUNC) ? segFunc_next :
    8'h00;

  // Segment pins show raw levels even in segment mode; software must not trust them

  // Pin drive
  assign anaPinOut_next = anaLatch_next;
  assign anaPinOe_next = anaDir_next;
  assign segPinOut_next = segFunc_next & lcdSegmentDrive;
  assign segPinOe_next = segFunc_next | ~segLatch_next;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      anaLatch_reg <= `DPA_RST_ANALOG_PORT_LATCH;
      anaDir_reg <= `DPA_RST_ANALOG_PORT_DIRECTION;
      anaInSel_reg <= `DPA_RST_ANALOG_PORT_INPUT_SELECT;
      segLatch_reg <= `DPA_RST_SEGMENT_PORT_LATCH;
      segFunc_reg <= `DPA_RST_SEGMENT_PORT_FUNCTION_SELECT;
    end else begin
      anaLatch_reg <= anaLatch_next;
      anaDir_reg <= anaDir_next;
      anaInSel_reg <= anaInSel_next;
      segLatch_reg <= segLatch_next;
      segFunc_reg <= segFunc_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      anaMeta_reg <= 8'h00;
      anaSync_reg <= 8'h00;
      segMeta_reg <= 8'h00;
      segSync_reg <= `DPA_RST_SEGMENT_PORT_PIN_READBACK;
    end else begin
      anaMeta_reg <= analogPinIn;
      anaSync_reg <= anaMeta_reg;
      segMeta_reg <= segmentPinIn;
      segSync_reg <= segMeta_reg;
    end
  end

  // Zero-wait slave: every transfer completes in its first data cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPending_reg <= 1'b0;
      wrSel_reg <= dpa_pkg::DPA_SEL_NONE;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `DPA_HRESP_OKAY;
    end else begin
      wrPending_reg <= addrPhase && hwrite;
      wrSel_reg <= addrSel;
      hrdata <= (addrPhase && !hwrite) ? {24'h000000, readByte} : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `DPA_HRESP_OKAY;
    end
  end

  // Digital input path gated off for analog pins to save the input buffer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      analogPinOut <= 8'h00;
      analogPinOe <= 8'h00;
      analogDigitalIn <= 8'h00;
      analogChannelEnable <= 8'h00;
      segmentPinOut <= 8'h00;
      segmentPinOe <= 8'h00;
    end else begin
      analogPinOut <= anaPinOut_next;
      analogPinOe <= anaPinOe_next;
      analogDigitalIn <= anaSync_reg & anaInSel_reg;
      analogChannelEnable <= ~anaInSel_reg & ~anaDir_reg;
      segmentPinOut <= segPinOut_next;
      segmentPinOe <= segPinOe_next;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_RESET_VALUES: assert property (
    disable iff (1'b0) !resetn |=> (segLatch_reg == 8'hff && segFunc_reg == 8'h00 &&
      anaLatch_reg == 8'h00 && anaDir_reg == 8'h00 && anaInSel_reg == 8'hff))
    else $error("Port registers wrong after reset");

  AST_ANALOG_RESET: assert property (
    disable iff (1'b0) !resetn ##1 resetn |-> (analogPinOe == 8'h00 && analogDigitalIn == 8'h00))
    else $error("Analog port pins not idle after reset");

  AST_SEG_LCD_DRIVE: assert property (
    segFunc_reg[0] && !wrPending_reg |=> segmentPinOe[0] &&
      segmentPinOut[0] == $past(lcdSegmentDrive[0]))
    else $error("Segment pin not driven by LCD segment drive");

  AST_SEG_OPEN_DRAIN: assert property (
    !segFunc_reg[1] && !wrPending_reg |=> segmentPinOut[1] == 1'b0 &&
      segmentPinOe[1] == !$past(segLatch_reg[1]))
    else $error("Segment port pin drive does not follow latch");

  AST_ANA_DIRECTION: assert property (
    !wrPending_reg |=> analogPinOe == $past(anaDir_reg) && analogPinOut == $past(anaLatch_reg))
    else $error("Analog port drive does not follow direction and latch");

  AST_ANA_INPUT_GATE: assert property (
    !anaInSel_reg[2] |=> analogDigitalIn[2] == 1'b0)
    else $error("Digital input not gated for analog pin");

  AST_ANA_READ_ZERO: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_ANA_LATCH
      |=> (hrdata[7:0] & ~$past(anaDir_reg) & ~$past(anaInSel_reg)) == 8'h00)
    else $error("Analog port read not zero in analog mode");

  AST_ANA_READ_PIN: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_ANA_LATCH &&
      !anaDir_reg[4] && anaInSel_reg[4] |=> hrdata[4] == $past(anaSync_reg[4]))
    else $error("Input mode read does not return pin level");

  AST_SEG_LATCH_READ: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_SEG_LATCH
      |=> hrdata == {24'h000000, $past(segLatch_reg)})
    else $error("Segment latch read wrong");

  AST_SEG_READBACK_ADDR: assert property (
    addrPhase && !hwrite && addrInRange && regIndex == `DPA_IDX_SEGMENT_PORT_PIN_READBACK
      |=> hrdata == {24'h000000, $past(segSync_reg)})
    else $error("Pin readback not at its own address");

  AST_ALWAYS_READY: assert property (
    hreadyout && hresp == `DPA_HRESP_OKAY)
    else $error("Slave not ready or not OKAY");

  AST_RESET_BUS_IDLE: assert property (
    disable iff (1'b0) !resetn |=> hreadyout && hrdata == 32'h00000000 &&
      segmentPinOe == 8'h00 && analogPinOe == 8'h00)
    else $error("Bus or pins not idle after reset");

  // Whole-port checks; the single-bit ones above give readable failures
  AST_ANA_READ_LATCH: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_ANA_LATCH
      |=> ((hrdata[7:0] ^ $past(anaLatch_reg)) & $past(anaDir_reg)) == 8'h00)
    else $error("Output mode read does not return latch");

  AST_ANA_READ_PIN_ALL: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_ANA_LATCH
      |=> ((hrdata[7:0] ^ $past(anaSync_reg)) & ~$past(anaDir_reg) &
      $past(anaInSel_reg)) == 8'h00)
    else $error("Input mode pins read wrong");

  AST_DIR_READ: assert property (
    addrPhase && !hwrite && !wrPending_reg && addrSel == dpa_pkg::DPA_SEL_ANA_DIR
      |=> hrdata[7:0] == $past(anaDir_reg))
    else $error("Direction register read wrong");

  AST_READ_UPPER_ZERO: assert property (
    hrdata[31:8] == 24'h000000)
    else $error("Read data above the byte not zero");

  AST_UNMAPPED_READ: assert property (
    addrPhase && !hwrite && addrSel == dpa_pkg::DPA_SEL_NONE |=> hrdata == 32'h00000000)
    else $error("Unmapped read not zero");

  AST_IDLE_READ_DATA: assert property (
    !(addrPhase && !hwrite) |=> hrdata == 32'h00000000)
    else $error("Read data not cleared outside a read");

  // Each write lands at the end of its data phase
  AST_WRITE_ANA_LATCH: assert property (
    wrAnaLatch |=> anaLatch_reg == $past(hwdata[7:0]))
    else $error("Analog latch write lost");

  AST_WRITE_SEG_LATCH: assert property (
    wrSegLatch |=> segLatch_reg == $past(hwdata[7:0]))
    else $error("Segment latch write lost");

  AST_WRITE_ANA_DIR: assert property (
    wrAnaDir |=> anaDir_reg == $past(hwdata[7:0]))
    else $error("Direction write lost");

  AST_WRITE_ANA_INSEL: assert property (
    wrAnaInSel |=> anaInSel_reg == $past(hwdata[7:0]))
    else $error("Input select write lost");

  AST_WRITE_SEG_FUNC: assert property (
    wrSegFunc |=> segFunc_reg == $past(hwdata[7:0]))
    else $error("Segment select write lost");

  AST_READBACK_NO_WRITE: assert property (
    wrPending_reg && wrSel_reg == dpa_pkg::DPA_SEL_SEG_READBACK
      |=> $stable(segLatch_reg) && $stable(segFunc_reg) && $stable(anaLatch_reg) &&
      $stable(anaDir_reg) && $stable(anaInSel_reg))
    else $error("Write to pin readback changed a register");

  AST_DIGITAL_IN_GATE: assert property (
    1'b1 |=> analogDigitalIn == ($past(anaSync_reg) & $past(anaInSel_reg)) &&
      analogChannelEnable == (~$past(anaInSel_reg) & ~$past(anaDir_reg)))
    else $error("Digital input or channel enable wrong");

  AST_SEG_PINS_ALL: assert property (
    !wrPending_reg |=> segmentPinOut == ($past(segFunc_reg) & $past(lcdSegmentDrive)) &&
      segmentPinOe == ($past(segFunc_reg) | ~$past(segLatch_reg)))
    else $error("Segment port drive wrong");

  AST_READBACK_SYNC: assert property (
    1'b1 |=> segSync_reg == $past(segMeta_reg) && anaSync_reg == $past(anaMeta_reg))
    else $error("Pin synchroniser stage skipped");

  // Pins follow a register write at the edge that loads the register
  AST_ANA_OUT_ON_WRITE: assert property (
    wrAnaLatch |=> analogPinOut == $past(hwdata[7:0]))
    else $error("Analog pin output late after latch write");

  AST_ANA_OE_ON_DIR: assert property (
    wrAnaDir |=> analogPinOe == $past(hwdata[7:0]))
    else $error("Analog pin enable late after direction write");

  AST_SEG_OE_ON_SELECT: assert property (
    wrSegFunc |=> segmentPinOe == ($past(hwdata[7:0]) | ~$past(segLatch_reg)))
    else $error("Segment pin enable late after select write");

  AST_SEG_OE_ON_LATCH: assert property (
    wrSegLatch |=> segmentPinOe == ($past(segFunc_reg) | ~$past(hwdata[7:0])))
    else $error("Segment pin enable late after latch write");

endmodule

//--- bench/dpa_pin_model.sv
module dpa_pin_model (
  input wire logic [7:0] analogPinOut,
  input wire logic [7:0] analogPinOe,
  input wire logic [7:0] analogDrive,
  input wire logic [7:0] segmentPinOut,
  input wire logic [7:0] segmentPinOe,
  input wire logic [7:0] segmentDrive,
  output logic [7:0] analogPinIn,
  output logic [7:0] segmentPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released bits show the outside source level
  assign analogPinIn = (analogPinOe & analogPinOut) | (~analogPinOe & analogDrive);
  assign segmentPinIn = (segmentPinOe & segmentPinOut) | (~segmentPinOe & segmentDrive);
endmodule

//--- bench/tb.sv
`include "dpa_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0] analog_channel_input, aOut, aOe, aDig, aChan, sIn, sOut, sOe;
  // Outside source levels aDrv and sDrv stay steady for the whole test; lcd changes in the segment test
  logic [7:0] lcd = 8'h00, aDrv = 8'ha5, sDrv = 8'h96;
  logic [7:0] rd, dir, ins, lat, pin, ex;
  logic [7:0] cfgDir [2] = '{8'h0f, 8'hf0};
  logic [7:0] cfgIns [2] = '{8'h33, 8'hcc};
  int n_fail = 0;
  int n_checks = 0;
  localparam logic [31:0] A_AL = {18'h0, `DPA_IDX_ANALOG_PORT_LATCH, 2'h0};
  localparam logic [31:0] A_SL = {18'h0, `DPA_IDX_SEGMENT_PORT_LATCH, 2'h0};
  localparam logic [31:0] A_AD = {18'h0, `DPA_IDX_ANALOG_PORT_DIRECTION, 2'h0};
  localparam logic [31:0] A_AI = {18'h0, `DPA_IDX_ANALOG_PORT_INPUT_SELECT, 2'h0};
  localparam logic [31:0] A_RB = {18'h0, `DPA_IDX_SEGMENT_PORT_PIN_READBACK, 2'h0};
  localparam logic [31:0] A_SF = {18'h0, `DPA_IDX_SEGMENT_PORT_FUNCTION_SELECT, 2'h0};

  always #5 clock = ~clock;

  dpa_port_io DUT (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analogPinIn(analog_channel_input),
    .analogPinOut(aOut), .analogPinOe(aOe), .analogDigitalIn(aDig),
    .analogChannelEnable(aChan), .segmentPinIn(sIn), .segmentPinOut(sOut),
    .segmentPinOe(sOe), .lcdSegmentDrive(lcd));

  dpa_pin_model pins (.analogPinOut(aOut), .analogPinOe(aOe), .analogDrive(aDrv),
    .segmentPinOut(sOut), .segmentPinOe(sOe), .segmentDrive(sDrv),
    .analogPinIn(analog_channel_input), .segmentPinIn(sIn));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fail("bus hang");
        report_and_stop;
      end
      @(posedge clock);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `DPA_HTRANS_NONSEQ;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy;
    rd = hrdata[7:0];
    chk({7'h0, hresp}, 8'h00, "response");
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [7:0] exp, input string m);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp, m);
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
  endtask

  initial begin
    do_reset;
    rdchk(A_SL, 8'hff, "seg latch reset");
    rdchk(A_SF, 8'h00, "seg select reset");
    rdchk(A_AD, 8'h00, "direction reset");
    rdchk(A_AI, 8'hff, "input select reset");
    rdchk(A_AL, aDrv, "input pin read");
    rdchk(A_RB, sDrv, "seg readback");
    chk(sOe, 8'h00, "seg released");
    rdchk(32'h20, 8'h00, "unmapped read");
    xfer(1'b1, A_RB, 8'h00);
    rdchk(A_SL, 8'hff, "readback write ignored");
    xfer(1'b1, A_AD, 8'hff);
    rdchk(A_AL, 8'h00, "analog latch reset");
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      dir = cfgDir[i];
      ins = cfgIns[i];
      lat = 8'h3c;
      xfer(1'b1, A_AL, lat);
      xfer(1'b1, A_AD, dir);
      xfer(1'b1, A_AI, ins);
      repeat (3) @(posedge clock);
      pin = (dir & lat) | (~dir & aDrv);
      ex = (dir & lat) | (~dir & ins & pin);
      rdchk(A_AL, ex, "analog read");
      chk(aOe, dir, "analog oe");
      chk(aOut, lat, "analog out");
      chk(aChan, ~dir & ~ins, "analog channel");
      chk(aDig, pin & ins, "digital input");
    end
    // Write back what was read, as a bit operation would
    xfer(1'b1, A_AL, ex);
    xfer(1'b1, A_AI, 8'hff);
    xfer(1'b1, A_AD, 8'hff);
    rdchk(A_AL, ex, "latch after rmw");
    $display("test analog done");
    xfer(1'b1, A_SF, 8'h81);
    for (int i = 0; i < 2; i++) begin
      lat = i ? 8'hf0 : 8'h0f;
      lcd <= i ? 8'h7e : 8'hc3;
      xfer(1'b1, A_SL, lat);
      repeat (3) @(posedge clock);
      rdchk(A_SL, lat, "seg latch read");
      chk(sOe, 8'h81 | ~lat, "seg oe");
      chk(sOut, 8'h81 & lcd, "seg lcd drive");
      xfer(1'b0, A_RB, 8'h00);
      chk(rd & 8'h7e, lat & sDrv & 8'h7e, "seg pins");
    end
    $display("test segment done");
    do_reset;
    rdchk(A_SL, 8'hff, "seg latch rereset");
    rdchk(A_SF, 8'h00, "seg select rereset");
    chk(sOe, 8'h00, "seg oe rereset");
    rdchk(A_AD, 8'h00, "direction rereset");
    $display("test rereset done");
    report_and_stop;
  end
endmodule
